// ==== core/cise_defines.svh ====
`ifndef CISE_DEFINES_SVH
`define CISE_DEFINES_SVH

// ============================================================================
// Instruction word layout (14-bit word).
`define CISE_IW_W          14
`define CISE_FADDR_W       7
`define CISE_DEST_BIT      7
`define CISE_LIT8_W        8
`define CISE_LIT11_W       11
`define CISE_PC_W          15
`define CISE_PAGE_LO       3
`define CISE_PAGE_HI       6

// ============================================================================
// Opcode patterns and masks.
`define CISE_OP_DEC_MASK   14'h3F00
`define CISE_OP_DEC        14'h0300
`define CISE_OP_DSZ        14'h0B00
`define CISE_OP_ISZ        14'h0F00
`define CISE_OP_CLR_ACC_MASK 14'h3F80
`define CISE_OP_CLR_ACC    14'h0100
`define CISE_OP_JMP_MASK   14'h3800
`define CISE_OP_JMP        14'h2800
`define CISE_OP_ORL        14'h3800

// ============================================================================
// Reset values.
`define CISE_ACC_RST       8'h00
`define CISE_PC_RST        15'h0000

`endif

// ==== core/cise_pkg.sv ====
package cise_pkg;
  typedef enum logic [2:0] {
    CISE_OP_NONE  = 3'b000,
    CISE_OP_DEC   = 3'b001,
    CISE_OP_DSZ   = 3'b010,
    CISE_OP_ISZ   = 3'b011,
    CISE_OP_CLR_ACC = 3'b100,
    CISE_OP_JMP   = 3'b101,
    CISE_OP_ORL   = 3'b110
  } cise_op_t;

  typedef enum logic [1:0] {
    CISE_ST_EXEC  = 2'b00,
    CISE_ST_FLUSH = 2'b01
  } cise_state_t;
endpackage

// ==== core/cise_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cise_defines.svh"

// Function
// - Decrement file register, result to accumulator or file per destination, update null flag.
// - Clear accumulator loads zero and always sets the null flag.
// - Decrement-with-skip stores result per destination and leaves flags unchanged.
// - Decrement-with-skip on zero result replaces next instruction with no-operation.
// - Jump loads literal into PC low bits, page latch bits 6..3 into PC 14..11.
// - Jump always takes two cycles, flushing the fetched next instruction.
// - Increment-with-skip stores result per destination and leaves flags unchanged.
// - Increment-with-skip on zero result replaces next instruction with no-operation.
// - OR literal into accumulator, write accumulator, update null flag.
module cise_exec (
  input  wire logic                       sys_clk_in,       // Core clock
  input  wire logic                       rst_n_in,         // Sync reset, active low
  input  wire logic                       instr_en_in,      // One-cycle instruction-cycle enable
  input  wire logic [`CISE_IW_W-1:0]      instr_in,         // Fetched instruction word
  input  wire logic [7:0]                 file_rd_data_in,  // Addressed file register value
  input  wire logic [7:0]                 page_latch_reg_in,// Page latch register
  input  wire logic                       null_flag_in,     // Current null-result flag
  output logic [`CISE_FADDR_W-1:0]        file_addr_out,    // File register address
  output logic                            file_wr_en_out,   // File write strobe (one cycle)
  output logic [7:0]                      file_wr_data_out, // File write data
  output logic [7:0]                      accum_out,        // Working register
  output logic                            null_flag_wr_out, // Null flag write strobe
  output logic                            null_flag_val_out,// Null flag value to write
  output logic [`CISE_PC_W-1:0]           pc_out,           // Program counter
  output logic                            flush_out         // Current cycle is a forced no-op
);

  // ==========================================================================
  // Decode. Each supported operation has one mask and one pattern; a hit
  // vector is formed per entry and the priority chain below picks among hits.
  localparam int unsigned num_ops = 6;
  localparam logic [`CISE_IW_W-1:0] op_mask [num_ops] = '{
    `CISE_OP_DEC_MASK, `CISE_OP_DEC_MASK, `CISE_OP_DEC_MASK,
    `CISE_OP_CLR_ACC_MASK, `CISE_OP_JMP_MASK, `CISE_OP_DEC_MASK
  };
  localparam logic [`CISE_IW_W-1:0] op_pat [num_ops] = '{
    `CISE_OP_DEC, `CISE_OP_DSZ, `CISE_OP_ISZ,
    `CISE_OP_CLR_ACC, `CISE_OP_JMP, `CISE_OP_ORL
  };

  cise_pkg::cise_op_t op;
  cise_pkg::cise_state_t state_q;
  logic [7:0] result;
  logic       is_zero;
  logic       dest_file;
  logic       executing;
  logic [num_ops-1:0]    op_hit;      // One hit per mask and pattern entry
  logic                  file_op;     // Decrement, decrement-skip or increment-skip
  logic                  skip_op;     // One of the two skip instructions
  logic                  flag_op;     // Operation that rewrites the null-result flag
  logic                  skip_taken;  // Skip instruction with a zero result
  logic                  file_write;  // File register write this cycle
  logic                  flag_value;  // Null-result flag value to write
  logic [`CISE_PC_W-1:0] jump_target; // Absolute jump destination

  for (genvar i = 0; i < num_ops; i++) begin : g_op_match
    assign op_hit[i] = ((instr_in & op_mask[i]) == op_pat[i]);
  end

  always_comb begin
    if (op_hit[0]) begin
      op = cise_pkg::CISE_OP_DEC;
    end else if (op_hit[1]) begin
      op = cise_pkg::CISE_OP_DSZ;
    end else if (op_hit[2]) begin
      op = cise_pkg::CISE_OP_ISZ;
    end else if (op_hit[3]) begin
      op = cise_pkg::CISE_OP_CLR_ACC;
    end else if (op_hit[4]) begin
      op = cise_pkg::CISE_OP_JMP;
    end else if (op_hit[5]) begin
      op = cise_pkg::CISE_OP_ORL;
    end else begin
      op = cise_pkg::CISE_OP_NONE;
    end
  end

  assign dest_file = instr_in[`CISE_DEST_BIT];
  assign executing = instr_en_in && (state_q == cise_pkg::CISE_ST_EXEC);
  assign flush_out = (state_q == cise_pkg::CISE_ST_FLUSH);
  assign file_addr_out = instr_in[`CISE_FADDR_W-1:0];
  assign file_op       = (op == cise_pkg::CISE_OP_DEC) || (op == cise_pkg::CISE_OP_DSZ) ||
                         (op == cise_pkg::CISE_OP_ISZ);
  assign skip_op       = (op == cise_pkg::CISE_OP_DSZ) || (op == cise_pkg::CISE_OP_ISZ);
  assign flag_op       = (op == cise_pkg::CISE_OP_DEC) || (op == cise_pkg::CISE_OP_CLR_ACC) ||
                         (op == cise_pkg::CISE_OP_ORL);
  assign skip_taken    = skip_op && is_zero;
  assign file_write    = executing && dest_file && file_op;
  assign jump_target   = {page_latch_reg_in[`CISE_PAGE_HI:`CISE_PAGE_LO],
                          instr_in[`CISE_LIT11_W-1:0]};

  // ==========================================================================
  // Arithmetic; 8-bit results wrap naturally.
  always_comb begin
    case (op)
      cise_pkg::CISE_OP_DEC,
      cise_pkg::CISE_OP_DSZ: result = file_rd_data_in - 8'h01;
      cise_pkg::CISE_OP_ISZ: result = file_rd_data_in + 8'h01;
      cise_pkg::CISE_OP_ORL: result = accum_out | instr_in[7:0];
      default:               result = 8'h00;
    endcase
  end

  assign is_zero = (result == 8'h00);

  // Clearing the accumulator forces the flag; every other writer reports zero.
  always_comb begin
    if (op == cise_pkg::CISE_OP_CLR_ACC) begin
      flag_value = 1'b1;
    end else begin
      flag_value = is_zero;
    end
  end

  // ==========================================================================
  // Sequencing: a skip with a zero result, or a jump, turns the next instruction cycle into a no-op.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_q <= cise_pkg::CISE_ST_EXEC;
    end else if (instr_en_in) begin
      case (state_q)
        cise_pkg::CISE_ST_EXEC: begin
          if (op == cise_pkg::CISE_OP_JMP) begin
            state_q <= cise_pkg::CISE_ST_FLUSH;
          end else if (skip_taken) begin
            state_q <= cise_pkg::CISE_ST_FLUSH;
          end else begin
            state_q <= cise_pkg::CISE_ST_EXEC;
          end
        end
        cise_pkg::CISE_ST_FLUSH: begin
          state_q <= cise_pkg::CISE_ST_EXEC;
        end
        default: state_q <= cise_pkg::CISE_ST_EXEC;
      endcase
    end
  end

  // ==========================================================================
  // Program counter; it advances on every instruction cycle, flushed ones included, except an executed jump, which loads jump_target.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pc_out <= `CISE_PC_RST;
    end else if (executing && op == cise_pkg::CISE_OP_JMP) begin
      pc_out <= jump_target;
    end else if (instr_en_in) begin
      pc_out <= pc_out + 15'h0001;
    end
  end

  // ==========================================================================
  // Working register.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      accum_out <= `CISE_ACC_RST;
    end else if (executing) begin
      case (op)
        cise_pkg::CISE_OP_CLR_ACC: accum_out <= 8'h00;
        cise_pkg::CISE_OP_ORL:  accum_out <= result;
        cise_pkg::CISE_OP_DEC,
        cise_pkg::CISE_OP_DSZ,
        cise_pkg::CISE_OP_ISZ: begin
          if (!dest_file) begin
            accum_out <= result;
          end
        end
        default: accum_out <= accum_out;
      endcase
    end
  end

  // ==========================================================================
  // File write and null flag strobes, one cycle each.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      file_wr_en_out   <= 1'b0;
      file_wr_data_out <= 8'h00;
    end else begin
      file_wr_en_out <= file_write;
      // Data moves only with the strobe, so an idle file bus stays quiet.
      if (file_write) begin
        file_wr_data_out <= result;
      end
    end
  end

  // Skip instructions never raise this strobe, so flags stay untouched.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      null_flag_wr_out  <= 1'b0;
      null_flag_val_out <= 1'b0;
    end else begin
      null_flag_wr_out  <= executing && flag_op;
      null_flag_val_out <= flag_value;
    end
  end

  // ==========================================================================
  // Elaboration checks. The operand fields are carved out of one fixed word,
  // so a layout constant edited on its own would silently misroute bits.
  if (`CISE_LIT11_W + `CISE_PAGE_HI - `CISE_PAGE_LO + 1 != `CISE_PC_W) begin : g_pc_w_chk
    $error("Jump target width does not match the program counter");
  end
  if (`CISE_DEST_BIT != `CISE_FADDR_W) begin : g_dest_chk
    $error("Destination bit must sit just above the file address");
  end
  if (`CISE_LIT8_W != 8 || `CISE_LIT11_W >= `CISE_IW_W) begin : g_lit_chk
    $error("Literal fields do not fit the instruction word");
  end
  for (genvar i = 0; i < num_ops; i++) begin : g_op_chk
    if ((op_pat[i] & ~op_mask[i]) != '0) begin : g_bad
      $error("Opcode pattern has bits outside its mask");
    end
  end

  // The incoming flag is for the core's own status path; unused here.
  logic unused_flag;
  assign unused_flag = null_flag_in;

endmodule
`default_nettype wire

// ==== bench/cise_exec_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Checker. Expected results are captured one edge ahead in helper flops, so
// each property except pc_step_a, which uses $past(pc_out), compares an output against its cause rather than itself.
module cise_exec_asserts (
  input wire logic        sys_clk_in,        // Clock
  input wire logic        rst_n_in,          // Reset
  input wire logic        instr_en_in,       // Enable
  input wire logic [13:0] instr_in,          // Word
  input wire logic [7:0]  file_rd_data_in,   // File value
  input wire logic [7:0]  page_latch_reg_in, // Page latch
  input wire logic        file_wr_en_out,    // File strobe
  input wire logic [7:0]  file_wr_data_out,  // File data
  input wire logic [7:0]  accum_out,         // Working reg
  input wire logic        null_flag_wr_out,  // Flag strobe
  input wire logic        null_flag_val_out, // Flag value
  input wire logic [14:0] pc_out,            // Counter
  input wire logic        flush_out          // Forced no-op
);
  logic        go;
  logic        skip_q;
  logic [7:0]  orl_q;
  logic [7:0]  dec_q;
  logic [14:0] tgt_q;
  assign go = instr_en_in && !flush_out;
  always_ff @(posedge sys_clk_in) begin
    skip_q <= instr_in[10] ? (file_rd_data_in == 8'hFF) : (file_rd_data_in == 8'h01);
    orl_q  <= accum_out | instr_in[7:0];
    dec_q  <= file_rd_data_in - 8'h01;
    tgt_q  <= {page_latch_reg_in[6:3], instr_in[10:0]};
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  clear_acc_a: assert property (go && instr_in[13:7] == 7'h02 |=> accum_out == 8'h00
    && null_flag_wr_out && null_flag_val_out) else $error("clear result wrong");
  skip_flags_a: assert property (go && instr_in[13:11] == 3'b001 && instr_in[9:8] == 2'b11
    |=> !null_flag_wr_out) else $error("skip wrote flag");
  dsz_skip_a: assert property (go && instr_in[13:8] == 6'h0B
    |=> flush_out == skip_q) else $error("decrement skip wrong");
  isz_skip_a: assert property (go && instr_in[13:8] == 6'h0F
    |=> flush_out == skip_q) else $error("increment skip wrong");
  jump_target_a: assert property (go && instr_in[13:11] == 3'b101
    |=> pc_out == tgt_q && flush_out) else $error("jump wrong");
  or_literal_a: assert property (go && instr_in[13:8] == 6'h38
    |=> accum_out == orl_q) else $error("or result wrong");
  dec_write_a: assert property (go && instr_in[13:7] == 7'h07 |=> file_wr_en_out
    && file_wr_data_out == dec_q && null_flag_wr_out && null_flag_val_out == (dec_q == 8'h00))
    else $error("decrement write wrong");
  pc_step_a: assert property (instr_en_in && !(go && instr_in[13:11] == 3'b101)
    |=> pc_out == $past(pc_out) + 15'h0001) else $error("pc step wrong");
endmodule
bind cise_exec cise_exec_asserts u_chk (.sys_clk_in, .rst_n_in, .instr_en_in, .instr_in,
  .file_rd_data_in, .page_latch_reg_in, .file_wr_en_out, .file_wr_data_out, .accum_out,
  .null_flag_wr_out, .null_flag_val_out, .pc_out, .flush_out);
`default_nettype wire

// ==== bench/cise_exec_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cise_exec_tb;
  localparam logic [13:0] BASE [8] = '{14'h0300, 14'h0B00, 14'h0F00, 14'h0100,
                                       14'h2800, 14'h3800, 14'h1000, 14'h0B00};
  localparam logic [13:0] MASK [8] = '{14'h00FF, 14'h00FF, 14'h00FF, 14'h007F,
                                       14'h07FF, 14'h00FF, 14'h0000, 14'h00FF};
  logic        sys_clk_in, rst_n_in, instr_en_in, null_flag_in, m_fl;
  logic        file_wr_en_out, null_flag_wr_out, null_flag_val_out, flush_out;
  logic [13:0] instr_in;
  logic [7:0]  file_rd_data_in, page_latch_reg_in, file_wr_data_out, accum_out, m_acc, r;
  logic [6:0]  file_addr_out;
  logic [14:0] pc_out, m_pc;
  logic [10:0] p;
  logic [31:0] seed;
  int          fails, n_compared;
  cise_exec u_dut (.sys_clk_in, .rst_n_in, .instr_en_in, .instr_in, .file_rd_data_in,
    .page_latch_reg_in, .null_flag_in, .file_addr_out, .file_wr_en_out, .file_wr_data_out,
    .accum_out, .null_flag_wr_out, .null_flag_val_out, .pc_out, .flush_out);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR t=%0t %s mismatch", $time, what);
    end
  endtask
  task automatic conclude;
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #400000;
    fails++;
    conclude;
  end
  // ==========================================================================
  // Random stream; the strobe word is {file wr, file data, flag wr, flag value}.
  initial begin
    {rst_n_in, instr_en_in, instr_in, file_rd_data_in, page_latch_reg_in, null_flag_in} = '0;
    {m_acc, m_pc, m_fl, p} = '0;
    seed = 32'h4CD5;
    repeat (5) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    repeat (3000) begin
      chk({accum_out, pc_out, flush_out} === {m_acc, m_pc, m_fl}, "state");
      chk({file_wr_en_out, file_wr_en_out ? file_wr_data_out : 8'h00, null_flag_wr_out,
           null_flag_wr_out & null_flag_val_out} === p, "strobe");
      chk(file_addr_out === instr_in[6:0], "address");
      p = '0;
      seed = xs(seed);
      instr_in = BASE[seed[10:8]] | (seed[27:14] & MASK[seed[10:8]]);
      instr_en_in = |seed[1:0];
      page_latch_reg_in = seed[31:24];
      file_rd_data_in = seed[12] ? seed[23:16] : (seed[13] ? 8'hFF : 8'h01);
      if (instr_en_in) begin
        m_pc = m_pc + 15'h0001;
        if (m_fl) m_fl = 1'b0;
        else if (instr_in[13:11] == 3'b101) begin
          m_pc = {page_latch_reg_in[6:3], instr_in[10:0]};
          m_fl = 1'b1;
        end else if (instr_in[13:7] == 7'h02) begin
          m_acc = 8'h00;
          p = 11'h003;
        end else if (instr_in[13:8] == 6'h38) begin
          m_acc = m_acc | instr_in[7:0];
          p[1:0] = {1'b1, m_acc == 8'h00};
        end else if (instr_in[13:8] inside {6'h03, 6'h0B, 6'h0F}) begin
          r = instr_in[10] ? file_rd_data_in + 8'h01 : file_rd_data_in - 8'h01;
          if (instr_in[7]) p[10:2] = {1'b1, r};
          else m_acc = r;
          if (instr_in[11]) m_fl = (r == 8'h00);
          else p[1:0] = {1'b1, r == 8'h00};
        end
      end
      @(negedge sys_clk_in);
    end
    conclude;
  end
endmodule
`default_nettype wire
